/* rtl/adcp_ctrl.sv */
// converter control: registers, sequencer, compare window, write guard
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
module adcp_ctrl #(
    parameter logic [23:0] GUARD_KEY = 24'h5a_c3_e1  // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_trigger,
    input wire logic [2:0] timer_trigger,
    output logic conv_start,
    output logic [3:0] conv_channel,
    input wire logic conv_done,
    input wire logic [9:0] conv_data,
    output logic dma_req,
    output logic [15:0] dma_data,
    output logic irq
);
    logic sw_reset;
    logic clr;
    logic acc;
    logic wr_pend;
    adcp_pkg::adcp_bus_req_t dreq;
    logic prot;
    logic wr_ok;
    logic key_ok;
    logic [31:0] mode_config;
    logic [31:0] sequence_low;
    logic [31:0] sequence_high;
    logic [15:0] chan_en;
    logic [31:0] extended_config;
    logic [31:0] compare_window;
    logic [31:0] irq_mask;
    logic drdy;
    logic compare_event_flag;
    logic write_guard_enable;
    logic write_guard_violation;
    logic [7:0] write_guard_violation_source;
    logic [9:0] chan_result [16];
    logic [15:0] last_result;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [7:0] cdr_off;
    logic [8:0] div_cnt;
    logic tick;
    adcp_pkg::adcp_state_t st;
    logic [3:0] slot;
    logic [9:0] cnt;
    logic [9:0] startup_len;
    logic [4:0] first;
    logic [4:0] nxt;
    logic trig_level;
    logic trig_prev;
    logic start_cmd;
    logic start_req;
    logic store;
    logic [9:0] res_val;
    logic [15:0] next_last;
    logic cmp_hit;
    logic [11:0] cmp_val;

    // soft reset clears everything the hardware reset clears
    assign clr = !resetn || sw_reset;
    // the bus is only used while clk_en is high
    assign acc = clk_en && hsel && hready && htrans[1];

    // one-cycle pulse; a second write while it is high is blocked by the !sw_reset term
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sw_reset <= 1'b0;
        end else if (clk_en) begin
            sw_reset <= wr_pend && dreq.addr == adcp_pkg::OFF_CONTROL &&
                        hwdata[adcp_pkg::CR_SOFT_RESET] && !sw_reset;
        end
    end

    // zero-wait slave: read data is latched in the address phase
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            wr_pend <= 1'b0;
            dreq <= '0;
            hrdata <= adcp_pkg::REG_RESET;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_pend <= acc && hwrite;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (acc) begin
                dreq <= '{addr: haddr[7:0], write: hwrite};
            end
            if (acc && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_comb begin
        case (dreq.addr)
            adcp_pkg::OFF_MODE, adcp_pkg::OFF_SEQ_LOW, adcp_pkg::OFF_SEQ_HIGH,
            adcp_pkg::OFF_CHAN_SET, adcp_pkg::OFF_CHAN_CLR, adcp_pkg::OFF_EXT,
            adcp_pkg::OFF_WINDOW: prot = 1'b1;
            default: prot = 1'b0;
        endcase
    end
    assign wr_ok = wr_pend && !(write_guard_enable && prot);
    assign key_ok = hwdata[31:adcp_pkg::WG_KEY] == GUARD_KEY;

    // configuration; unlisted offsets fall to default and change nothing
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            mode_config <= adcp_pkg::REG_RESET;
            sequence_low <= adcp_pkg::REG_RESET;
            sequence_high <= adcp_pkg::REG_RESET;
            chan_en <= '0;
            extended_config <= adcp_pkg::REG_RESET;
            compare_window <= adcp_pkg::REG_RESET;
            irq_mask <= adcp_pkg::REG_RESET;
        end else if (clk_en && wr_ok) begin
            case (dreq.addr)
                adcp_pkg::OFF_MODE: mode_config <= hwdata & adcp_pkg::MR_MASK;
                adcp_pkg::OFF_SEQ_LOW: sequence_low <= hwdata;
                adcp_pkg::OFF_SEQ_HIGH: sequence_high <= hwdata;
                adcp_pkg::OFF_CHAN_SET: chan_en <= chan_en | hwdata[15:0];
                adcp_pkg::OFF_CHAN_CLR: chan_en <= chan_en & ~hwdata[15:0];
                adcp_pkg::OFF_EXT: extended_config <= hwdata & adcp_pkg::EMR_MASK;
                adcp_pkg::OFF_WINDOW: compare_window <= hwdata & adcp_pkg::CWR_MASK;
                adcp_pkg::OFF_IRQ_SET: irq_mask <= irq_mask | (hwdata & adcp_pkg::IRQ_MASK_BITS);
                adcp_pkg::OFF_IRQ_CLR: irq_mask <= irq_mask & ~hwdata;
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    // guard: a keyless write to its own config is ignored altogether
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            write_guard_enable <= 1'b0;
            write_guard_violation <= 1'b0;
            write_guard_violation_source <= '0;
        end else if (clk_en && wr_pend) begin
            if (dreq.addr == adcp_pkg::OFF_GUARD_CFG && key_ok) begin
                write_guard_enable <= hwdata[adcp_pkg::WG_EN];
                write_guard_violation <= 1'b0;
            end else if (prot && write_guard_enable) begin
                write_guard_violation <= 1'b1;
                write_guard_violation_source <= dreq.addr;
            end
        end
    end

    assign status_word = ({31'h0, drdy} << adcp_pkg::ISR_DRDY) |
                         ({31'h0, compare_event_flag} << adcp_pkg::ISR_COMPARE_EVENT_FLAG);
    assign cdr_off = haddr[7:0] - adcp_pkg::OFF_CDR_FIRST;

    always_comb begin
        case (haddr[7:0])
            adcp_pkg::OFF_MODE: rd_mux = mode_config;
            adcp_pkg::OFF_SEQ_LOW: rd_mux = sequence_low;
            adcp_pkg::OFF_SEQ_HIGH: rd_mux = sequence_high;
            adcp_pkg::OFF_CHAN_STATE: rd_mux = {16'h0000, chan_en};
            adcp_pkg::OFF_LAST: rd_mux = {16'h0000, last_result};
            adcp_pkg::OFF_IRQ_MASK: rd_mux = irq_mask;
            adcp_pkg::OFF_IRQ_STATUS: rd_mux = status_word;
            adcp_pkg::OFF_EXT: rd_mux = extended_config;
            adcp_pkg::OFF_WINDOW: rd_mux = compare_window;
            adcp_pkg::OFF_GUARD_CFG: rd_mux = {31'h0, write_guard_enable};
            adcp_pkg::OFF_GUARD_STAT: rd_mux = {16'h0000, write_guard_violation_source,
                                               7'h00, write_guard_violation};
            default: begin
                rd_mux = adcp_pkg::REG_RESET;
                if (haddr[7:0] >= adcp_pkg::OFF_CDR_FIRST &&
                    haddr[7:0] <= adcp_pkg::OFF_CDR_LAST && haddr[1:0] == 2'b00) begin
                    rd_mux = {22'h0, chan_result[cdr_off[5:2]]};
                end
            end
        endcase
    end

    // conversion clock as a tick, period 2*(prescaler+1) main clocks
    assign tick = div_cnt == {mode_config[adcp_pkg::MR_CLOCK_DIVIDER_SETTING +: 8], 1'b1};
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            div_cnt <= '0;
        end else if (clk_en) begin
            div_cnt <= tick ? 9'h000 : div_cnt + 9'h001;
        end
    end

    always_comb begin
        case (mode_config[adcp_pkg::MR_TRG_SEL +: 3])
            adcp_pkg::TRG_EXT: trig_level = ext_trigger;
            adcp_pkg::TRG_TIMER0: trig_level = timer_trigger[0];
            adcp_pkg::TRG_TIMER1: trig_level = timer_trigger[1];
            adcp_pkg::TRG_TIMER2: trig_level = timer_trigger[2];
            default: trig_level = 1'b0;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            trig_prev <= 1'b0;
        end else if (clk_en) begin
            trig_prev <= trig_level;
        end
    end

    assign start_cmd = wr_pend && dreq.addr == adcp_pkg::OFF_CONTROL &&
                       hwdata[adcp_pkg::CR_START];
    // triggers arriving mid-sequence are dropped, not queued
    assign start_req = start_cmd ||
                       (mode_config[adcp_pkg::MR_TRG_EN] && trig_level && !trig_prev) ||
                       mode_config[adcp_pkg::MR_CONTINUOUS_CONVERSION];
    assign startup_len = adcp_pkg::adcp_startup_periods(
                             mode_config[adcp_pkg::MR_STARTUP +: 4]);
    assign first = adcp_pkg::adcp_next_slot(5'h00, chan_en);
    assign nxt = adcp_pkg::adcp_next_slot({1'b0, slot} + 5'h01, chan_en);
    assign store = clk_en && st == adcp_pkg::ST_CONVERT && conv_done;

    // same slot walk on every trigger keeps the buffer layout fixed
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            st <= adcp_pkg::ST_IDLE;
            slot <= '0;
            cnt <= '0;
            conv_start <= 1'b0;
            conv_channel <= '0;
        end else if (clk_en) begin
            conv_start <= 1'b0;
            case (st)
                adcp_pkg::ST_IDLE: begin
                    if (start_req && first[4]) begin
                        slot <= first[3:0];
                        cnt <= '0;
                        st <= startup_len == '0 ? adcp_pkg::ST_TRACK : adcp_pkg::ST_STARTUP;
                    end
                end
                adcp_pkg::ST_STARTUP: begin
                    if (tick) begin
                        cnt <= cnt + 10'h001;
                        if (cnt == startup_len - 10'h001) begin
                            cnt <= '0;
                            st <= adcp_pkg::ST_TRACK;
                        end
                    end
                end
                adcp_pkg::ST_TRACK: begin
                    if (tick) begin
                        cnt <= cnt + 10'h001;
                        if (cnt == {6'h00, mode_config[adcp_pkg::MR_TRACK +: 4]}) begin
                            cnt <= '0;
                            st <= adcp_pkg::ST_CONVERT;
                            conv_start <= 1'b1;
                            conv_channel <= adcp_pkg::adcp_slot_channel(slot,
                                mode_config[adcp_pkg::MR_USE_SEQ], {sequence_high, sequence_low});
                        end
                    end
                end
                adcp_pkg::ST_CONVERT: begin
                    if (conv_done) begin
                        if (nxt[4]) begin
                            slot <= nxt[3:0];
                            st <= adcp_pkg::ST_TRACK;
                        end else if (mode_config[adcp_pkg::MR_CONTINUOUS_CONVERSION] && first[4]) begin
                            slot <= first[3:0];
                            st <= adcp_pkg::ST_TRACK;
                        end else begin
                            st <= adcp_pkg::ST_IDLE;
                        end
                    end
                end
                default: st <= adcp_pkg::ST_IDLE;
            endcase
        end
    end

    assign res_val = mode_config[adcp_pkg::MR_LOW_RES] ?
                     {2'b00, conv_data[9:2]} : conv_data;
    assign next_last = {extended_config[adcp_pkg::EMR_TAG] ? conv_channel : 4'h0,
                        2'b00, res_val};
    assign cmp_val = {2'b00, res_val};

    always_comb begin
        case (extended_config[adcp_pkg::EMR_CMP_MODE +: 2])
            adcp_pkg::CMP_LOW: cmp_hit = cmp_val < compare_window[adcp_pkg::CWR_LOW +: 12];
            adcp_pkg::CMP_HIGH: cmp_hit = cmp_val > compare_window[adcp_pkg::CWR_HIGH +: 12];
            adcp_pkg::CMP_IN: cmp_hit = cmp_val >= compare_window[adcp_pkg::CWR_LOW +: 12] &&
                                        cmp_val <= compare_window[adcp_pkg::CWR_HIGH +: 12];
            default: cmp_hit = cmp_val < compare_window[adcp_pkg::CWR_LOW +: 12] ||
                               cmp_val > compare_window[adcp_pkg::CWR_HIGH +: 12];
        endcase
        if (!extended_config[adcp_pkg::EMR_COMPARE_ALL_CHANNELS] &&
            conv_channel != extended_config[adcp_pkg::EMR_CMP_SEL +: 4]) begin
            cmp_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            for (int i = 0; i < 16; i++) begin
                chan_result[i] <= '0;
            end
            last_result <= '0;
            dma_req <= 1'b0;
            dma_data <= '0;
        end else if (clk_en) begin
            dma_req <= store;
            if (store) begin
                chan_result[conv_channel] <= res_val;
                last_result <= next_last;
                dma_data <= next_last;
            end
        end
    end

    // clear on read first, so a same-cycle event wins
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            drdy <= 1'b0;
            compare_event_flag <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            if (acc && !hwrite && haddr[7:0] == adcp_pkg::OFF_LAST) begin
                drdy <= 1'b0;
            end
            if (acc && !hwrite && haddr[7:0] == adcp_pkg::OFF_IRQ_STATUS) begin
                compare_event_flag <= 1'b0;
            end
            if (store) begin
                drdy <= 1'b1;
            end
            if (store && cmp_hit) begin
                compare_event_flag <= 1'b1;
            end
            irq <= |(status_word & irq_mask);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (clr);

    dma_request_a: assert property (store |=> dma_req && dma_data == last_result)
        else $error("dma request missing after result store");
    dma_tag_a: assert property (store && extended_config[adcp_pkg::EMR_TAG] |=>
        dma_data[15:12] == $past(conv_channel))
        else $error("dma half-word lacks channel tag");
    guard_block_a: assert property (clk_en && wr_pend && prot && write_guard_enable |=>
        write_guard_violation && $stable(mode_config) && $stable(compare_window))
        else $error("protected write not blocked");
    guard_source_a: assert property (clk_en && wr_pend && prot && write_guard_enable |=>
        write_guard_violation_source == $past(dreq.addr))
        else $error("violation source wrong");
    key_clear_a: assert property (clk_en && wr_pend && dreq.addr == adcp_pkg::OFF_GUARD_CFG &&
        key_ok |=> !write_guard_violation)
        else $error("violation flag not cleared by key");
    soft_reset_a: assert property (disable iff (!resetn) clk_en && wr_pend && !sw_reset &&
        dreq.addr == adcp_pkg::OFF_CONTROL && hwdata[adcp_pkg::CR_SOFT_RESET]
        |=> sw_reset ##1 mode_config == '0 && chan_en == '0)
        else $error("soft reset did not clear state");
    start_seq_a: assert property (clk_en && st == adcp_pkg::ST_IDLE && start_cmd && first[4]
        |=> st != adcp_pkg::ST_IDLE)
        else $error("start command ignored");
    no_trigger_a: assert property (clk_en && st == adcp_pkg::ST_IDLE && !start_cmd &&
        !mode_config[adcp_pkg::MR_TRG_EN] && !mode_config[adcp_pkg::MR_CONTINUOUS_CONVERSION]
        |=> st == adcp_pkg::ST_IDLE)
        else $error("sequence started without trigger");
    track_len_a: assert property (st == adcp_pkg::ST_TRACK |->
        cnt <= {6'h00, mode_config[adcp_pkg::MR_TRACK +: 4]})
        else $error("tracking interval overran");
    compare_flag_a: assert property (store && cmp_hit |=> compare_event_flag)
        else $error("compare match not flagged");
    low_res_a: assert property (store && mode_config[adcp_pkg::MR_LOW_RES] |=>
        last_result[9:8] == 2'b00)
        else $error("low resolution result too wide");

    seq_done_c: cover property (st == adcp_pkg::ST_CONVERT ##1 st == adcp_pkg::ST_IDLE);
    compare_c: cover property (store && cmp_hit);
    violation_c: cover property ($rose(write_guard_violation));
    continuous_conversion_c: cover property (store && mode_config[adcp_pkg::MR_CONTINUOUS_CONVERSION] && !nxt[4]);
endmodule : adcp_ctrl

/* rtl/adcp_pkg.sv */
// constants, types and helpers shared by the converter control block
package adcp_pkg;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_SEQ_LOW = 8'h08;
    localparam logic [7:0] OFF_SEQ_HIGH = 8'h0c;
    localparam logic [7:0] OFF_CHAN_SET = 8'h10;
    localparam logic [7:0] OFF_CHAN_CLR = 8'h14;
    localparam logic [7:0] OFF_CHAN_STATE = 8'h18;
    localparam logic [7:0] OFF_LAST = 8'h20;
    localparam logic [7:0] OFF_IRQ_SET = 8'h24;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFF_OVERRUN = 8'h3c;
    localparam logic [7:0] OFF_EXT = 8'h40;
    localparam logic [7:0] OFF_WINDOW = 8'h44;
    localparam logic [7:0] OFF_CDR_FIRST = 8'h50;
    localparam logic [7:0] OFF_CDR_LAST = 8'h8c;
    localparam logic [7:0] OFF_GUARD_CFG = 8'he4;
    localparam logic [7:0] OFF_GUARD_STAT = 8'he8;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int CR_SOFT_RESET = 0;
    localparam int CR_START = 1;
    localparam int MR_TRG_EN = 0;
    localparam int MR_TRG_SEL = 1;
    localparam int MR_LOW_RES = 4;
    localparam int MR_CONTINUOUS_CONVERSION = 7;
    localparam int MR_CLOCK_DIVIDER_SETTING = 8;
    localparam int MR_STARTUP = 16;
    localparam int MR_TRACK = 24;
    localparam int MR_USE_SEQ = 31;
    localparam logic [31:0] MR_MASK = 32'h8f0f_ffff;
    localparam int EMR_CMP_MODE = 0;
    localparam int EMR_CMP_SEL = 4;
    localparam int EMR_COMPARE_ALL_CHANNELS = 9;
    localparam int EMR_TAG = 24;
    localparam logic [31:0] EMR_MASK = 32'h0100_02f3;
    localparam int CWR_LOW = 0;
    localparam int CWR_HIGH = 16;
    localparam logic [31:0] CWR_MASK = 32'h0fff_0fff;
    localparam int ISR_DRDY = 24;
    localparam int ISR_COMPARE_EVENT_FLAG = 26;
    localparam logic [31:0] IRQ_MASK_BITS = 32'h0500_0000;
    localparam int WG_EN = 0;
    localparam int WG_KEY = 8;
    localparam int WG_SRC = 8;
    localparam int RES_W = 10;
    localparam logic [2:0] TRG_EXT = 3'h0;
    localparam logic [2:0] TRG_TIMER0 = 3'h1;
    localparam logic [2:0] TRG_TIMER1 = 3'h2;
    localparam logic [2:0] TRG_TIMER2 = 3'h3;
    localparam logic [1:0] CMP_LOW = 2'h0;
    localparam logic [1:0] CMP_HIGH = 2'h1;
    localparam logic [1:0] CMP_IN = 2'h2;
    localparam logic [1:0] CMP_OUT = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_STARTUP = 4'h2,
        ST_TRACK = 4'h4,
        ST_CONVERT = 4'h8
    } adcp_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
    } adcp_bus_req_t;

    // start-up periods of the conversion clock per code
    function automatic logic [9:0] adcp_startup_periods(input logic [3:0] code);
        case (code)
            4'h0: return 10'd0;
            4'h1: return 10'd8;
            4'h2: return 10'd16;
            4'h3: return 10'd24;
            4'h4: return 10'd64;
            4'h5: return 10'd80;
            4'h6: return 10'd96;
            4'h7: return 10'd112;
            4'h8: return 10'd512;
            4'h9: return 10'd576;
            4'ha: return 10'd640;
            4'hb: return 10'd704;
            4'hc: return 10'd768;
            4'hd: return 10'd832;
            4'he: return 10'd896;
            default: return 10'd960;
        endcase
    endfunction : adcp_startup_periods

    // first enabled slot at or above from; bit 4 says one was found
    function automatic logic [4:0] adcp_next_slot(input logic [4:0] from,
                                                  input logic [15:0] en);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (5'(i) >= from && en[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : adcp_next_slot

    // channel converted in a slot: user order or plain numeric order
    function automatic logic [3:0] adcp_slot_channel(input logic [3:0] slot,
                                                     input logic use_seq,
                                                     input logic [63:0] seq);
        return use_seq ? seq[{slot, 2'b00} +: 4] : slot;
    endfunction : adcp_slot_channel
endpackage : adcp_pkg

/* verif/adcp_core_model.sv */
// behavioural analog core answering each conversion request
`timescale 1ns/10ps
module adcp_core_model (
    input wire logic clk_sys,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel,
    output logic conv_done,
    output logic [9:0] conv_data
);
    logic [2:0] cnt = 3'h0;
    initial conv_done = 1'b0;
    initial conv_data = 10'h000;
    always @(posedge clk_sys) begin
        cnt <= conv_start ? 3'h4 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
        conv_done <= (cnt == 3'h1);
        // data toggles off the done cycle so a stale capture never matches
        conv_data <= (cnt == 3'h1) ? {6'h15, conv_channel} : ~conv_data;
    end
endmodule : adcp_core_model

/* verif/tb_top.sv */
// self-checking bench: registers, conversion, compare, write guard
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic ext_trigger = 1'b0;
    logic [2:0] timer_trigger = 3'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, conv_start, conv_done, dma_req, irq;
    logic [3:0] conv_channel;
    logic [9:0] conv_data;
    logic [15:0] dma_data;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    always #4 clk_sys = ~clk_sys;
    adcp_ctrl DUT (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_trigger(ext_trigger), .timer_trigger(timer_trigger), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data),
        .dma_req(dma_req), .dma_data(dma_data), .irq(irq));
    adcp_core_model core (.clk_sys(clk_sys), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data));
    task automatic stop_test;
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // skips the edge of a pulse already seen, then waits for the next half-word
    task automatic wait_dma;
        @(posedge clk_sys);
        for (int i = 0; i < 400 && dma_req !== 1'b1; i++) @(posedge clk_sys);
    endtask : wait_dma
    task automatic test_window;
        bus(1, adcp_pkg::OFF_WINDOW, 32'hfabc_f123);
        bus(0, adcp_pkg::OFF_WINDOW, 32'h0);
        chk(rd, 32'h0abc_0123);
        // probe only: nothing else here relies on a reserved offset
        bus(0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        bus(1, adcp_pkg::OFF_CONTROL, 32'h1);
        repeat (2) @(posedge clk_sys);
        bus(0, adcp_pkg::OFF_WINDOW, 32'h0);
        chk(rd, 32'h0);
    endtask : test_window
    task automatic test_convert;
        bus(1, adcp_pkg::OFF_CHAN_SET, 32'h4);
        bus(1, adcp_pkg::OFF_EXT, 32'h201);
        bus(1, adcp_pkg::OFF_IRQ_SET, 32'h0400_0000);
        bus(1, adcp_pkg::OFF_CONTROL, 32'h2);
        wait_dma();
        chk({16'h0, dma_data}, 32'h0000_0152);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        bus(0, adcp_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0500_0000);
    endtask : test_convert
    task automatic test_guard;
        bus(1, adcp_pkg::OFF_GUARD_CFG, 32'h5ac3_e101);
        bus(1, adcp_pkg::OFF_MODE, 32'h10);
        bus(0, adcp_pkg::OFF_MODE, 32'h0);
        chk(rd, 32'h0);
        bus(0, adcp_pkg::OFF_GUARD_STAT, 32'h0);
        chk(rd, 32'h0000_0401);
        bus(1, adcp_pkg::OFF_GUARD_CFG, 32'h5ac3_e100);
        bus(0, adcp_pkg::OFF_GUARD_STAT, 32'h0);
        chk(rd & 32'h1, 32'h0);
        bus(1, adcp_pkg::OFF_MODE, 32'h10);
        bus(0, adcp_pkg::OFF_MODE, 32'h0);
        chk(rd, 32'h10);
    endtask : test_guard
    task automatic test_trigger;
        int n;
        n = 0;
        bus(1, adcp_pkg::OFF_CHAN_CLR, 32'h0000_ffff);
        bus(1, adcp_pkg::OFF_CHAN_SET, 32'h0000_000a);
        bus(1, adcp_pkg::OFF_EXT, 32'h0100_0000);
        // timer 1 trigger, 8-bit, prescaler 1, start-up code 1, tracking 2
        bus(1, adcp_pkg::OFF_MODE, 32'h0201_0115);
        ext_trigger <= 1'b1;
        timer_trigger <= 3'h5;
        repeat (60) begin
            @(posedge clk_sys);
            if (conv_start === 1'b1) n++;
        end
        chk(n, 32'h0);
        ext_trigger <= 1'b0;
        timer_trigger <= 3'h2;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (conv_start !== 1'b1 && n < 200);
        // 8 start-up and 3 tracking periods of 4 clocks, plus up to one period of phase
        chk({31'h0, n >= 43 && n <= 46}, 32'h1);
        wait_dma();
        chk({16'h0, dma_data}, 32'h0000_1054);
        wait_dma();
        chk({16'h0, dma_data}, 32'h0000_3054);
        bus(0, adcp_pkg::OFF_LAST, 32'h0);
        chk(rd, 32'h0000_3054);
        timer_trigger <= 3'h0;
    endtask : test_trigger
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        test_window();
        test_convert();
        test_guard();
        test_trigger();
        stop_test();
    end
endmodule : tb_top
